// File: hdl/motor_slave_pkg.sv
// Constants and carrier types for the motor slave request handler
package motor_slave_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ      = 100_000_000;
    localparam int TICK_HZ     = 512;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    // ----------------------------------------------------------------
    // Request codes and acknowledgments
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_STATE  = 8'h2A;
    localparam logic [7:0] CMD_STOP   = 8'h58;
    localparam logic [7:0] CMD_FILTER = 8'h46;
    localparam logic [7:0] CMD_PIN    = 8'h43;
    localparam logic [7:0] CMD_DOUT   = 8'h44;
    localparam logic [7:0] CMD_MOTOR  = 8'h4D;
    localparam logic [7:0] CMD_SLEW   = 8'h57;
    localparam logic [7:0] ACK_OK       = 8'h00;
    localparam logic [7:0] ACK_BAD_PORT = 8'h01;
    localparam logic [7:0] ACK_BAD_PARM = 8'h02;
    localparam logic [7:0] ACK_UNKNOWN  = 8'h03;
    // ----------------------------------------------------------------
    // Motor directions and limits
    // ----------------------------------------------------------------
    localparam logic [1:0] DIR_OFF = 2'h0;
    localparam logic [1:0] DIR_FWD = 2'h1;
    localparam logic [1:0] DIR_REV = 2'h2;
    localparam logic [7:0] MOTOR_MAX  = 8'h03;
    localparam logic [7:0] CHAN8_MAX  = 8'h07;
    localparam logic [7:0] PIN_MAX    = 8'h03;
    localparam logic [7:0] LPF_MAX    = 8'h0F;
    localparam logic [7:0] DOUT_MAX   = 8'h01;
    localparam logic [7:0] MODE_MAX   = 8'h0F;
    // ----------------------------------------------------------------
    // Reply layout: byte index = printed offset - REPLY_BASE
    // ----------------------------------------------------------------
    localparam int REPLY_BASE = 3;
    localparam int OFS_QUAD0  = 7;
    localparam int OFS_ERR0   = 10;
    localparam int OFS_QUAD1  = 11;
    localparam int OFS_ERR1   = 12;
    localparam int OFS_MOTOR  = 13;
    localparam int OFS_DIR    = 25;
    localparam int OFS_ANALOG = 27;
    localparam int OFS_LPF    = 43;
    localparam int STATE_LEN  = 44;
    localparam int RX_BYTES   = 4;
    // ----------------------------------------------------------------
    // Registers and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int         CTRL_STOP  = 0;
    localparam int         CTRL_RUN   = 1;
    localparam logic [7:0] CTRL_RST   = 8'h02;
    localparam logic [7:0] SLEW_RST   = 8'hFF;
    localparam logic [7:0] PWM_RST    = 8'h00;
    localparam logic [3:0] NIB_RST    = 4'h0;
    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] dir;
        logic [7:0] pwm;
        logic       brake;
    } motor_drive_type;
    typedef struct packed {
        logic [15:0] count;
        logic [7:0]  errors;
    } quad_type;
endpackage

// File: hdl/motor_slave_request_handler.sv
// Slave request handler: decodes motor, pin and filter requests and replies
`timescale 1ns/100ps
module motor_slave_request_handler
    import motor_slave_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  rx_valid_i,
    input  wire logic [7:0]            rx_data_i,
    input  wire logic                  rx_last_i,
    output logic                       rx_ready_o,
    output logic                       tx_valid_o,
    output logic [7:0]                 tx_data_o,
    output logic                       tx_last_o,
    input  wire logic                  tx_ready_i,
    input  wire logic                  estop_i,
    input  wire logic [3:0]            din_i,
    input  wire quad_type [1:0]        quad_i,
    input  wire logic [7:0][15:0]      analog_i,
    output motor_drive_type [3:0]      motor_o,
    output logic [3:0][3:0]            pin_mode_o,
    output logic [7:0]                 dout_o,
    output logic [7:0][3:0]            lpf_o,
    input  wire logic [3:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic [7:0]                 reg_rdata_o
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} state_type;
    localparam int TW = $clog2(TICK_DIV + 1);

    state_type         state_q;
    logic [7:0]        rxb_q [RX_BYTES];
    logic [2:0]        rx_cnt_q;
    logic [5:0]        tx_idx_q;
    logic [7:0]        tx_data_q;
    logic              tx_state_q;
    logic [TW-1:0]     tick_cnt_q;
    logic              tick;
    logic [7:0]        ctrl_q;
    logic [1:0]        last_ack_q;
    logic              estop_q;
    logic [7:0]        rdata_q;
    logic [7:0]        goal_pwm_q [4];
    logic [7:0]        act_pwm_q  [4];
    logic [7:0]        slew_q     [4];
    logic [1:0]        goal_dir_q [4];
    logic [1:0]        act_dir_q  [4];
    logic [3:0]        pin_mode_q [4];
    logic [3:0]        lpf_q      [8];
    logic [3:0]        moving;
    logic [7:0]        st_byte    [STATE_LEN];

    // Request fields, command byte first
    wire logic [7:0] cmd = rxb_q[0];
    wire logic [7:0] ch  = rxb_q[1];
    wire logic [7:0] p1  = rxb_q[2];
    wire logic [7:0] p2  = rxb_q[3];
    wire logic       exec = (state_q == ST_EXEC);
    wire logic       tx_hs = (state_q == ST_TX) && tx_ready_i;
    wire logic       tx_end = tx_state_q ? (tx_idx_q == 6'(STATE_LEN - 1)) : 1'b1;

    // ----------------------------------------------------------------
    // Request decode and acknowledgment
    // ----------------------------------------------------------------
    // Ack code selection
    wire logic [7:0] ack_motor = (ch > MOTOR_MAX || p1 > {6'h0, DIR_REV}) ? ACK_BAD_PARM : ACK_OK;
    wire logic [7:0] ack_slew  = (ch > MOTOR_MAX || p1 == 8'h00) ? ACK_BAD_PARM : ACK_OK;
    wire logic [7:0] ack_filt  = (ch > CHAN8_MAX) ? ACK_BAD_PORT :
                                 (p1 > LPF_MAX) ? ACK_BAD_PARM : ACK_OK;
    wire logic [7:0] ack_dout  = (ch > CHAN8_MAX) ? ACK_BAD_PORT :
                                 (p1 > DOUT_MAX) ? ACK_BAD_PARM : ACK_OK;
    wire logic [7:0] ack_pin   = (ch > PIN_MAX) ? ACK_BAD_PORT :
                                 (p1 > MODE_MAX) ? ACK_BAD_PARM : ACK_OK;
    wire logic [7:0] ack_code  = (cmd == CMD_STOP)   ? ACK_OK    :
                                 (cmd == CMD_MOTOR)  ? ack_motor :
                                 (cmd == CMD_SLEW)   ? ack_slew  :
                                 (cmd == CMD_FILTER) ? ack_filt  :
                                 (cmd == CMD_DOUT)   ? ack_dout  :
                                 (cmd == CMD_PIN)    ? ack_pin   : ACK_UNKNOWN;
    wire logic       ack_ok    = exec && (ack_code == ACK_OK);
    wire logic       is_state  = (cmd == CMD_STATE);

    wire logic estop_edge = estop_i && !estop_q;
    wire logic soft_stop  = reg_wr_i && (reg_addr_i == REG_CTRL) && reg_wdata_i[CTRL_STOP];
    wire logic stop_all   = (ack_ok && cmd == CMD_STOP) || estop_edge || soft_stop;

    // ----------------------------------------------------------------
    // Packet sequencing
    // ----------------------------------------------------------------
    // Receive is closed while a reply drains, so the master sees back-pressure
    assign rx_ready_o = (state_q == ST_RX);
    assign tx_valid_o = (state_q == ST_TX);
    assign tx_data_o  = tx_data_q;
    assign tx_last_o  = (state_q == ST_TX) && tx_end;

    // Sequencer: gather bytes, execute once, then drain the reply
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q    <= ST_RX;
            rx_cnt_q   <= 3'h0;
            tx_idx_q   <= 6'h00;
            tx_data_q  <= 8'h00;
            tx_state_q <= 1'b0;
            last_ack_q <= 2'h0;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (rx_valid_i) begin
                        rx_cnt_q <= rx_last_i ? 3'h0 :
                                    (rx_cnt_q < 3'(RX_BYTES)) ? rx_cnt_q + 3'h1 : rx_cnt_q;
                        if (rx_last_i) begin
                            state_q <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    tx_state_q <= is_state;
                    tx_data_q  <= is_state ? CMD_STATE : ack_code;
                    tx_idx_q   <= 6'h00;
                    if (!is_state) begin
                        last_ack_q <= ack_code[1:0];
                    end
                    state_q <= ST_TX;
                end
                ST_TX: begin
                    if (tx_hs) begin
                        tx_idx_q  <= tx_idx_q + 6'h01;
                        tx_data_q <= tx_end ? 8'h00 : st_byte[6'(tx_idx_q + 6'h01)];
                        if (tx_end) begin
                            state_q <= ST_RX;
                        end
                    end
                end
                default: state_q <= ST_RX;
            endcase
        end
    end

    // Request byte store; bytes past the fourth are ignored
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < RX_BYTES; i++) begin
                rxb_q[i] <= 8'h00;
            end
        end else if (rx_ready_o && rx_valid_i && rx_cnt_q < 3'(RX_BYTES)) begin
            rxb_q[rx_cnt_q[1:0]] <= rx_data_i;
        end
    end

    // ----------------------------------------------------------------
    // Slew tick, edge capture and software registers
    // ----------------------------------------------------------------
    assign tick = (tick_cnt_q == TW'(TICK_DIV - 1)) && ctrl_q[CTRL_RUN];

    // Tick divider; halting it freezes ramps for bench stepping
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt_q <= '0;
            estop_q    <= 1'b0;
            ctrl_q     <= CTRL_RST;
            rdata_q    <= 8'h00;
        end else begin
            tick_cnt_q <= (tick_cnt_q == TW'(TICK_DIV - 1)) ? '0 : tick_cnt_q + TW'(1);
            estop_q    <= estop_i;
            if (reg_wr_i && reg_addr_i == REG_CTRL) begin
                ctrl_q <= reg_wdata_i & ~(8'h01 << CTRL_STOP);
            end
            rdata_q <= !reg_rd_i ? 8'h00 :
                       (reg_addr_i == REG_CTRL)   ? ctrl_q :
                       (reg_addr_i == REG_STATUS) ? {moving, 1'b0, (state_q != ST_RX),
                                                     last_ack_q} : 8'h00;
        end
    end
    assign reg_rdata_o = rdata_q;

    // ----------------------------------------------------------------
    // Per-motor goal and ramp
    // ----------------------------------------------------------------
    for (genvar m = 0; m < 4; m++) begin : g_motor
        // Motor set stores direction and goal
        wire logic set_we  = ack_ok && cmd == CMD_MOTOR && ch[1:0] == 2'(m);
        wire logic slew_we = ack_ok && cmd == CMD_SLEW && ch[1:0] == 2'(m);
        wire logic [7:0] up_gap = goal_pwm_q[m] - act_pwm_q[m];
        wire logic [7:0] dn_gap = act_pwm_q[m] - goal_pwm_q[m];
        wire logic [7:0] to_zero = (act_pwm_q[m] > slew_q[m]) ? act_pwm_q[m] - slew_q[m] : 8'h00;

        // Goal side; stop wins over a set in the same cycle
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                goal_pwm_q[m] <= PWM_RST;
                goal_dir_q[m] <= DIR_OFF;
                slew_q[m]     <= SLEW_RST;
            end else begin
                if (stop_all) begin
                    goal_pwm_q[m] <= PWM_RST;
                end else if (set_we) begin
                    goal_pwm_q[m] <= p2;
                end
                if (set_we && !stop_all) begin
                    goal_dir_q[m] <= p1[1:0];
                end
                if (slew_we) begin
                    slew_q[m] <= p1;
                end
            end
        end

        // Ramp by slew, reverse only at zero
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                act_pwm_q[m] <= PWM_RST;
                act_dir_q[m] <= DIR_OFF;
            end else if (tick) begin
                if (act_dir_q[m] != goal_dir_q[m]) begin
                    if (act_pwm_q[m] == 8'h00) begin
                        act_dir_q[m] <= goal_dir_q[m];
                    end else begin
                        act_pwm_q[m] <= to_zero;
                    end
                end else if (act_pwm_q[m] < goal_pwm_q[m]) begin
                    act_pwm_q[m] <= (up_gap > slew_q[m]) ? act_pwm_q[m] + slew_q[m]
                                                         : goal_pwm_q[m];
                end else begin
                    act_pwm_q[m] <= (dn_gap > slew_q[m]) ? act_pwm_q[m] - slew_q[m]
                                                         : goal_pwm_q[m];
                end
            end
        end

        assign motor_o[m].dir   = act_dir_q[m];
        assign motor_o[m].pwm   = act_pwm_q[m];
        assign motor_o[m].brake = (act_dir_q[m] == DIR_FWD || act_dir_q[m] == DIR_REV)
                                  && act_pwm_q[m] == 8'h00;
        assign moving[m] = (act_pwm_q[m] != goal_pwm_q[m]) || (act_dir_q[m] != goal_dir_q[m]);
        assign st_byte[OFS_MOTOR - REPLY_BASE + 3*m]     = goal_pwm_q[m];
        assign st_byte[OFS_MOTOR - REPLY_BASE + 3*m + 1] = act_pwm_q[m];
        assign st_byte[OFS_MOTOR - REPLY_BASE + 3*m + 2] = slew_q[m];
    end

    // ----------------------------------------------------------------
    // Pin modes, digital outputs and filters
    // ----------------------------------------------------------------
    // Port 16-19 pins and current filters kept here
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dout_o <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                pin_mode_q[i] <= NIB_RST;
            end
            for (int i = 0; i < 8; i++) begin
                lpf_q[i] <= NIB_RST;
            end
        end else if (ack_ok) begin
            if (cmd == CMD_PIN) begin
                pin_mode_q[ch[1:0]] <= p1[3:0];
            end
            if (cmd == CMD_DOUT) begin
                dout_o[ch[2:0]] <= p1[0];
            end
            if (cmd == CMD_FILTER) begin
                lpf_q[ch[2:0]] <= p1[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // State reply snapshot, indexed from offset 3
    // ----------------------------------------------------------------
    assign st_byte[0] = CMD_STATE;
    assign st_byte[1] = {pin_mode_q[1], pin_mode_q[0]};
    assign st_byte[2] = {pin_mode_q[3], pin_mode_q[2]};
    assign st_byte[3] = {4'h0, din_i};
    assign st_byte[OFS_QUAD0 - REPLY_BASE]     = quad_i[0].count[15:8];
    assign st_byte[OFS_QUAD0 - REPLY_BASE + 1] = quad_i[0].count[7:0];
    assign st_byte[OFS_QUAD0 - REPLY_BASE + 2] = 8'h00;
    assign st_byte[OFS_ERR0 - REPLY_BASE]      = quad_i[0].errors;
    assign st_byte[OFS_QUAD1 - REPLY_BASE]     = quad_i[1].count[7:0];
    assign st_byte[OFS_ERR1 - REPLY_BASE]      = quad_i[1].errors;
    assign st_byte[OFS_DIR - REPLY_BASE]     = {act_dir_q[1], goal_dir_q[1],
                                                act_dir_q[0], goal_dir_q[0]};
    assign st_byte[OFS_DIR - REPLY_BASE + 1] = {act_dir_q[3], goal_dir_q[3],
                                                act_dir_q[2], goal_dir_q[2]};
    for (genvar a = 0; a < 8; a++) begin : g_analog
        assign st_byte[OFS_ANALOG - REPLY_BASE + 2*a]     = analog_i[a][15:8];
        assign st_byte[OFS_ANALOG - REPLY_BASE + 2*a + 1] = analog_i[a][7:0];
        assign lpf_o[a] = lpf_q[a];
    end
    for (genvar f = 0; f < 4; f++) begin : g_filt
        assign st_byte[OFS_LPF - REPLY_BASE + f] = {lpf_q[2*f+1], lpf_q[2*f]};
        assign pin_mode_o[f] = pin_mode_q[f];
    end
endmodule

// File: tb/motor_slave_chk.sv
// Port-level assertions for the motor slave request handler
`timescale 1ns/100ps
module motor_slave_chk
    import motor_slave_pkg::*;
#(
    parameter int TICK_DIV = 8
) (
    input wire logic                  clk_i,
    input wire logic                  reset_n_i,
    input wire logic                  rx_valid_i,
    input wire logic                  rx_last_i,
    input wire logic                  rx_ready_o,
    input wire logic                  tx_valid_o,
    input wire logic [7:0]            tx_data_o,
    input wire logic                  tx_ready_i,
    input wire logic                  estop_i,
    input wire motor_drive_type [3:0] motor_o
);
    // One clock domain, all checks muted while reset is held
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // A request ends, one execute cycle follows, then the answer starts
    sequence s_last_taken; rx_valid_i && rx_ready_o && rx_last_i; endsequence
    sequence s_exec_reply; !rx_ready_o ##1 tx_valid_o; endsequence
    property p_reply_start; s_last_taken |=> s_exec_reply; endproperty
    a_reply_start: assert property (p_reply_start) else $error("reply late");
    property p_no_rx_in_reply; tx_valid_o |-> !rx_ready_o; endproperty
    a_no_rx_in_reply: assert property (p_no_rx_in_reply) else $error("rx open");
    property p_hold_reply;
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
    endproperty
    a_hold_reply: assert property (p_hold_reply) else $error("reply byte lost");
    // Per motor; the pacing check assumes the bench's divider of 8 cycles a tick
    for (genvar m = 0; m < 4; m++) begin : g_motor
        property p_brake;
            motor_o[m].brake == (motor_o[m].dir != DIR_OFF && motor_o[m].pwm == 8'h00);
        endproperty
        a_brake: assert property (p_brake) else $error("brake decode wrong");
        property p_dir_legal; motor_o[m].dir != 2'h3; endproperty
        a_dir_legal: assert property (p_dir_legal) else $error("bad direction");
        property p_dir_at_rest;
            $changed(motor_o[m].dir) |-> $past(motor_o[m].pwm) == 8'h00;
        endproperty
        a_dir_at_rest: assert property (p_dir_at_rest) else $error("flip in motion");
        property p_tick_pace;
            $changed(motor_o[m].pwm) |=> $stable(motor_o[m].pwm) [*7];
        endproperty
        a_tick_pace: assert property (p_tick_pace) else $error("pwm off tick");
        property p_estop_falls;
            $rose(estop_i) |-> ##3 (motor_o[m].pwm <= $past(motor_o[m].pwm)) [*8];
        endproperty
        a_estop_falls: assert property (p_estop_falls) else $error("pwm rose in stop");
    end
endmodule
bind motor_slave_request_handler motor_slave_chk #(.TICK_DIV(TICK_DIV)) chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .estop_i(estop_i), .motor_o(motor_o));

// File: tb/request_source.sv
// Behavioural request source standing in for the forwarding master
`timescale 1ns/100ps
module request_source (
    input  wire logic       clk_i,
    input  wire logic       ready_i,
    output logic            valid_o,
    output logic [7:0]      data_o,
    output logic            last_o,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_last_i,
    output logic            tx_ready_o
);
    logic [7:0] req [4];
    logic [7:0] rep [44];
    int         rn;
    logic       hung;
    // Idle link at time zero
    initial begin
        valid_o    = 1'b0;
        data_o     = 8'h00;
        last_o     = 1'b0;
        tx_ready_o = 1'b0;
        hung       = 1'b0;
    end
    // routed upstream already
    // Sends one request, then collects the reply, stalling every other cycle if slow
    task automatic xfer(input int n, input logic slow);
        int   k;
        logic done;
        @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            valid_o <= 1'b1;
            data_o  <= req[i];
            last_o  <= (i == n - 1);
            k = 0;
            do begin
                @(negedge clk_i);
                k++;
            end while (ready_i !== 1'b1 && k < 50);
            hung |= (ready_i !== 1'b1);
            @(posedge clk_i);
        end
        valid_o <= 1'b0;
        last_o  <= 1'b0;
        data_o  <= ~data_o;  // Released line must not look like a held byte
        rn = 0;
        k = 0;
        done = 1'b0;
        while (!done && k < 400) begin
            tx_ready_o <= slow ? (k % 2 == 1) : 1'b1;
            @(negedge clk_i);
            if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
                rep[rn % 44] = tx_data_i;
                rn++;
                done = (tx_last_i === 1'b1);
            end
            @(posedge clk_i);
            k++;
        end
        tx_ready_o <= 1'b0;
        hung |= !done;
    endtask
endmodule

// File: tb/test_motor_slave_request_handler.sv
// Self-checking bench for the motor slave request handler
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", n, e, a); end end
module test_motor_slave_request_handler;
    import motor_slave_pkg::*;
    logic                  clk_i, reset_n_i, rx_valid_i, rx_last_i, rx_ready_o, tx_valid_o;
    logic                  tx_last_o, tx_ready_i, estop_i, reg_wr_i, reg_rd_i;
    logic [7:0]            rx_data_i, tx_data_o, dout_o, reg_wdata_i, reg_rdata_o;
    logic [3:0]            din_i, reg_addr_i;
    quad_type [1:0]        quad_i;
    logic [7:0][15:0]      analog_i;
    motor_drive_type [3:0] motor_o;
    logic [3:0][3:0]       pin_mode_o;
    logic [7:0][3:0]       lpf_o;
    logic [39:0]           tbl [12];
    int                    err_total, n_compared;
    motor_slave_request_handler #(.TICK_DIV(8)) uut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
        .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .estop_i(estop_i),
        .din_i(din_i), .quad_i(quad_i), .analog_i(analog_i), .motor_o(motor_o),
        .pin_mode_o(pin_mode_o), .dout_o(dout_o), .lpf_o(lpf_o), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o));
    request_source src (
        .clk_i(clk_i), .ready_i(rx_ready_o), .valid_o(rx_valid_i), .data_o(rx_data_i),
        .last_o(rx_last_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));
    // Table entry: four request bytes, byte count, expected acknowledgment
    task automatic send(input logic [39:0] t, input logic slow);
        for (int k = 0; k < 4; k++) src.req[k] = t[39-8*k -: 8];
        src.xfer(int'(t[7:4]), slow);
    endtask
    task automatic ack(input logic [39:0] t);
        send(t, 1'b0);
        `CHK("ack length", 1, src.rn)
        `CHK("ack byte", {4'h0, t[3:0]}, src.rep[0])
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] m, e, input string n);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1 `CHK(n, e, reg_rdata_o & m)
    endtask
    // One-cycle register write strobe
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Main sequence; sensor inputs are fixed patterns so reply bytes are known
    initial begin
        reset_n_i   = 1'b0;
        estop_i     = 1'b0;
        din_i       = 4'hA;
        quad_i      = 48'h789A_BC12_3456;
        reg_addr_i  = 4'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        for (int k = 0; k < 8; k++) analog_i[k] = 16'hA05C + 16'(k * 256);
        tbl = '{40'h4D04_0110_42, 40'h4D00_0310_42, 40'h5700_0000_32, 40'h4304_0100_31,
                40'h4602_1000_32, 40'h4607_0500_30, 40'h4407_0100_30, 40'h4303_0900_30,
                40'h5701_0400_30, 40'h4D01_01C8_40, 40'h4D02_0200_40, 40'h1100_0000_13};
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        reg_rd(REG_CTRL, 8'hFF, CTRL_RST, "control reset");
        foreach (tbl[k]) ack(tbl[k]);
        reg_rd(REG_STATUS, 8'h0F, 8'h03, "last ack");
        `CHK("filter 7", 4'h5, lpf_o[7])
        `CHK("dout 7", 1'b1, dout_o[7])
        `CHK("pin mode 3", 4'h9, pin_mode_o[3])
        $display("test done: acknowledgments");
        send(40'h2A00_0000_10, 1'b1);
        `CHK("reply length", 44, src.rn)
        `CHK("echo", 8'h2A, src.rep[0])
        `CHK("pin modes 2-3", 8'h90, src.rep[2])
        `CHK("digital in", 8'h0A, src.rep[3])
        `CHK("count 0 high", 8'h12, src.rep[4])
        `CHK("errors 0", 8'h56, src.rep[7])
        `CHK("count 1 low", 8'h9A, src.rep[8])
        `CHK("errors 1", 8'hBC, src.rep[9])
        `CHK("slew 0", 8'hFF, src.rep[12])
        `CHK("goal 1", 8'hC8, src.rep[13])
        `CHK("slew 1", 8'h04, src.rep[15])
        `CHK("goal dirs 0-1", 8'h10, src.rep[22] & 8'h33)
        `CHK("goal dirs 2-3", 8'h02, src.rep[23] & 8'h33)
        for (int k = 0; k < 8; k++) begin
            `CHK("analog", 16'hA05C + 16'(k*256), {src.rep[24+2*k], src.rep[25+2*k]})
        end
        `CHK("filters 6-7", 8'h50, src.rep[43])
        $display("test done: state reply");
        repeat (600) @(posedge clk_i);
        `CHK("motor 1 ramp", {DIR_FWD, 8'hC8, 1'b0}, motor_o[1])
        `CHK("motor 2 brake", {DIR_REV, 8'h00, 1'b1}, motor_o[2])
        ack(40'h5800_0000_10);
        repeat (600) @(posedge clk_i);
        `CHK("all stop", {DIR_FWD, 8'h00, 1'b1}, motor_o[1])
        ack(40'h4D01_01C8_40);
        repeat (80) @(posedge clk_i);
        estop_i <= 1'b1;
        repeat (600) @(posedge clk_i);
        estop_i <= 1'b0;
        `CHK("button stop", {DIR_FWD, 8'h00, 1'b1}, motor_o[1])
        // Software stop with the tick halted, then released
        ack(40'h4D01_01C8_40);
        repeat (600) @(posedge clk_i);
        reg_wr(REG_CTRL, 8'h01);
        repeat (80) @(posedge clk_i);
        `CHK("tick halted", {DIR_FWD, 8'hC8, 1'b0}, motor_o[1])
        reg_rd(REG_STATUS, 8'hF0, 8'h20, "moving");
        reg_rd(REG_CTRL, 8'hFF, 8'h00, "stop bit");
        reg_wr(REG_CTRL, 8'h02);
        repeat (600) @(posedge clk_i);
        `CHK("register stop", {DIR_FWD, 8'h00, 1'b1}, motor_o[1])
        send(40'h2A00_0000_10, 1'b0);
        `CHK("dirs 0-1", 8'h50, src.rep[22])
        `CHK("dirs 2-3", 8'h0A, src.rep[23])
        `CHK("actual 1", 8'h00, src.rep[14])
        $display("test done: register stop");
        reg_rd(4'hF, 8'hFF, 8'h00, "unmapped");
        `CHK("link stall", 1'b0, src.hung)
        $display("test done: motion and stops");
        end_of_test();
    end
endmodule
